// [core/wdr_top.sv]
// watchdog timer with power-on, pin, low-supply and time-out reset control
// Operation
// - overflow while running resets the device
// - watchdog off makes its instructions no-ops
// - option on forces watchdog; else key decides
// - key 1010B disables and is power-up value
// - clock from crystal, sysclk/4 or slow RC
// - sysclk/4 source stops while halted
// - period is 2^(8+code) watchdog clocks
// - upper bits read zero, code resets 111
// - running time-out resets and sets flag
// - halted time-out wakes, clears pc, stack
// - pin, clear instructions and halt clear counter
// - option picks single or paired clearing
// - paired mode needs both distinct instructions
// - program counter zero after power-on
// - ports preset to inputs on power-on
// - wait reset delay after pin release
// - pin low while running restarts at zero
// - low supply reset equals pin reset
// - time-out and powerdown flags only, pin reset keeps them
// - halt sets powerdown flag, clear clears it
`timescale 1ns/10ps
`include "wdr_map.svh"

module wdr_top #(
	parameter int RSTD_CYCLES = `WDR_RSTD_CYCLES
) (
	input  wire logic                CLK,
	input  wire logic                NRST,
	input  wire wdr_pkg::wdr_cfg_t   CFG,
	input  wire wdr_pkg::wdr_instr_t INSTR,
	input  wire wdr_pkg::wdr_mem_t   MEM,
	input  wire logic                EXT_RESET_N,
	input  wire logic                LOW_SUPPLY_RESET,
	input  wire logic                WAKE_REQ,
	input  wire logic                CRYSTAL_CLK,
	input  wire logic                SLOW_RC_CLK,
	output logic [7:0]               MEM_RDATA,
	output logic                     CORE_RESET,
	output logic                     PC_CLEAR,
	output logic                     PC_STACK_CLEAR,
	output logic                     PORT_PRESET,
	output logic                     HALTED,
	output logic                     TIMEOUT_FLAG,
	output logic                     POWERDOWN_FLAG
);

	// time-out limit for a period code
	function automatic logic [`WDR_CNT_W-1:0] wdr_limit(
		input logic [`WDR_SEL_MSB:0] sel
	);
		return `WDR_CNT_W'((32'd1 << (`WDR_SEL_BASE + 32'(sel))) - 32'd1);
	endfunction

	// address match used by read and write decode
	function automatic logic wdr_hit(
		input logic [7:0] addr,
		input logic [7:0] reg_addr
	);
		return addr == reg_addr;
	endfunction

	wdr_pkg::wdr_state_t         state_q;
	wdr_pkg::wdr_state_t         state_d;
	logic [1:0]                  pin_q;
	logic [1:0]                  lowv_q;
	logic [31:0]                 dly_q;
	logic [`WDR_CNT_W-1:0]       cnt_q;
	logic [`WDR_SEL_MSB:0]       sel_q;
	logic [`WDR_KEY_MSB:0]       key_q;
	logic                        tmo_q;
	logic                        pwrdn_q;
	logic                        got1_q;
	logic                        got2_q;
	logic                        pcs_q;
	logic [7:0]                  rdata_q;
	logic [7:0]                  rdata_d;
	logic                        tick;
	logic                        ext_rst;
	logic                        wdt_on;
	logic                        running;
	logic                        halted;
	logic                        dly_done;
	logic                        timeout;
	logic                        clr_pair;
	logic                        clr_sw;
	logic                        clr_cnt;
	logic                        halt_go;
	logic                        wr_sel;
	logic                        wr_key;

	// pin and low-supply synchronisers
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pin_q <= 2'h0;
			lowv_q <= 2'h0;
		end else begin
			pin_q <= {pin_q[0], EXT_RESET_N};
			lowv_q <= {lowv_q[0], LOW_SUPPLY_RESET};
		end
	end

	// pin reset and low-supply reset act alike
	assign ext_rst = !pin_q[1] || lowv_q[1];

	// enable decode and state qualifiers
	assign wdt_on   = CFG.wdt_en || (key_q != `WDR_KEY_OFF);
	assign running  = state_q == wdr_pkg::WDR_ST_RUN;
	assign halted   = state_q == wdr_pkg::WDR_ST_HALT;
	assign dly_done = dly_q >= 32'(RSTD_CYCLES - 1);
	assign timeout  = wdt_on && tick && (cnt_q == wdr_limit(sel_q));
	assign halt_go  = running && INSTR.halt;

	// clearing: single instruction or a pair of distinct ones
	assign clr_pair = (INSTR.clr_first && got2_q)
	                || (INSTR.clr_second && got1_q);
	assign clr_sw   = wdt_on && running
	                && (CFG.pair_mode ? clr_pair : INSTR.clr_single);
	assign clr_cnt  = clr_sw || (halt_go && wdt_on) || !running && !halted
	                || timeout || ext_rst;

	// watchdog clock source
	wdr_tick u_tick (
		.clk         (CLK),
		.nrst        (NRST),
		.src         (CFG.clk_src),
		.halted      (halted),
		.crystal_clk (CRYSTAL_CLK),
		.slow_rc_clk (SLOW_RC_CLK),
		.tick        (tick)
	);

	// next state of the reset sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			wdr_pkg::WDR_ST_HOLD: begin
				if (!ext_rst)
					state_d = wdr_pkg::WDR_ST_DELAY;
			end
			wdr_pkg::WDR_ST_DELAY: begin
				if (ext_rst)
					state_d = wdr_pkg::WDR_ST_HOLD;
				else if (dly_done)
					state_d = wdr_pkg::WDR_ST_RUN;
			end
			wdr_pkg::WDR_ST_RUN: begin
				if (ext_rst)
					state_d = wdr_pkg::WDR_ST_HOLD;
				else if (timeout)
					state_d = wdr_pkg::WDR_ST_DELAY;
				else if (INSTR.halt)
					state_d = wdr_pkg::WDR_ST_HALT;
			end
			wdr_pkg::WDR_ST_HALT: begin
				if (ext_rst)
					state_d = wdr_pkg::WDR_ST_HOLD;
				else if (timeout || WAKE_REQ)
					state_d = wdr_pkg::WDR_ST_RUN;
			end
		endcase
	end

	// state and reset delay counter
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= wdr_pkg::WDR_ST_HOLD;
			dly_q   <= 32'h0;
		end else begin
			state_q <= state_d;
			dly_q   <= (state_q == wdr_pkg::WDR_ST_DELAY && !dly_done)
			           ? dly_q + 32'h1 : 32'h0;
		end
	end

	// watchdog counter
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			cnt_q <= '0;
		else if (clr_cnt || !wdt_on)
			cnt_q <= '0;
		else if (tick)
			cnt_q <= cnt_q + `WDR_CNT_W'(1);
	end

	// paired clear tracking, repeats of one half are ignored
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			got1_q <= 1'b0;
			got2_q <= 1'b0;
		end else if (!wdt_on || !running || clr_pair) begin
			got1_q <= 1'b0;
			got2_q <= 1'b0;
		end else begin
			got1_q <= got1_q || INSTR.clr_first;
			got2_q <= got2_q || INSTR.clr_second;
		end
	end

	// register write decode
	assign wr_sel = MEM.wr && wdr_hit(MEM.addr, `WDR_ADDR_PERIOD_SEL);
	assign wr_key = MEM.wr && wdr_hit(MEM.addr, `WDR_ADDR_CTRL_ONE);

	// period select and enable key
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sel_q <= `WDR_SEL_RESET;
			key_q <= `WDR_KEY_OFF;
		end else begin
			if (!running && !halted || timeout && running)
				sel_q <= `WDR_SEL_RESET;
			else if (wr_sel && running)
				sel_q <= MEM.wdata[`WDR_SEL_MSB:0];
			if (wr_key && running)
				key_q <= MEM.wdata[`WDR_KEY_MSB:0];
		end
	end

	// reset flags, a set wins over a clear in the same cycle
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			tmo_q   <= 1'b0;
			pwrdn_q <= 1'b0;
		end else begin
			if (timeout)
				tmo_q <= 1'b1;
			else if (halt_go)
				tmo_q <= 1'b0;
			if (halt_go && !timeout)
				pwrdn_q <= 1'b1;
			else if (clr_sw)
				pwrdn_q <= 1'b0;
		end
	end

	// wake pulse clearing program counter and stack pointer
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			pcs_q <= 1'b0;
		else
			pcs_q <= halted && timeout;
	end

	// register read mux, unmapped reads return zero
	assign rdata_d =
		wdr_hit(MEM.addr, `WDR_ADDR_PERIOD_SEL) ? {5'h00, sel_q} :
		wdr_hit(MEM.addr, `WDR_ADDR_CTRL_ONE)   ? {4'h0, key_q}  :
		wdr_hit(MEM.addr, `WDR_ADDR_STATUS)     ?
			8'(({7'h00, tmo_q} << `WDR_STAT_TMO_BIT)
			 | ({7'h00, pwrdn_q} << `WDR_STAT_PWRDN_BIT)) :
		8'h00;

	// registered read data
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			rdata_q <= 8'h00;
		else if (MEM.rd)
			rdata_q <= rdata_d;
	end

	// outputs
	assign MEM_RDATA      = rdata_q;
	assign CORE_RESET     = !running && !halted;
	assign PC_CLEAR       = CORE_RESET || pcs_q;
	assign PC_STACK_CLEAR = pcs_q;
	assign PORT_PRESET    = CORE_RESET;
	assign HALTED         = halted;
	assign TIMEOUT_FLAG   = tmo_q;
	assign POWERDOWN_FLAG = pwrdn_q;

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	sequence s_halt_entry;
		running && INSTR.halt && !ext_rst && !timeout;
	endsequence

	sequence s_halt_state;
		halted && pwrdn_q && cnt_q == '0;
	endsequence

	a_run_timeout: assert property (
		running && timeout && !ext_rst |=> CORE_RESET && tmo_q
		&& cnt_q == '0)
		else $error("running time-out did not reset");

	a_off_nop: assert property (
		!wdt_on && !CORE_RESET |=> cnt_q == '0
		&& ($stable(pwrdn_q) || $past(INSTR.halt)))
		else $error("disabled watchdog changed state");

	a_key_enable: assert property (
		wr_key && running && MEM.wdata[3:0] == `WDR_KEY_ON_ADVISED
		|=> wdt_on)
		else $error("advised key did not enable watchdog");

	a_sysdiv_stop: assert property (
		halted && CFG.clk_src == wdr_pkg::WDR_SRC_SYS_DIV4 ##1 halted
		|-> !tick)
		else $error("derived source ticked while halted");

	a_sel_read: assert property (
		MEM.rd |=> MEM_RDATA[7:3] == 5'h00 || !$past(wdr_hit(MEM.addr,
		`WDR_ADDR_PERIOD_SEL)))
		else $error("period select upper bits not zero");

	a_halt_wake: assert property (
		halted && timeout && !ext_rst |=> running && pwrdn_q && tmo_q
		##0 PC_STACK_CLEAR ##1 !PC_STACK_CLEAR)
		else $error("halted time-out wake wrong");

	a_halt_clear: assert property (
		s_halt_entry and wdt_on |=> s_halt_state)
		else $error("halt did not clear counter or set flag");

	a_pair_repeat: assert property (
		CFG.pair_mode && running && INSTR.clr_first && !got2_q && !tick
		&& !ext_rst && !timeout |=> !clr_pair || INSTR.clr_second)
		else $error("repeated first clear acted");

	a_delay_hold: assert property (
		$rose(state_q == wdr_pkg::WDR_ST_DELAY) && !ext_rst |->
		CORE_RESET [*8])
		else $error("reset delay ended early");

	a_pin_restart: assert property (
		running && ext_rst |=> PC_CLEAR && PORT_PRESET && cnt_q == '0)
		else $error("pin reset did not restart");

endmodule

// [include/wdr_map.svh]
// register map, reset values and timing constants of the watchdog block
`ifndef WDR_MAP_SVH
`define WDR_MAP_SVH

// data memory addresses of the block's registers
`define WDR_ADDR_PERIOD_SEL 8'h09
`define WDR_ADDR_CTRL_ONE   8'h0A
`define WDR_ADDR_STATUS     8'h0B

// field positions
`define WDR_SEL_MSB         2
`define WDR_KEY_MSB         3
`define WDR_STAT_TMO_BIT    5
`define WDR_STAT_PWRDN_BIT  4

// reset values and keys
`define WDR_SEL_RESET       3'h7
`define WDR_KEY_OFF         4'hA
`define WDR_KEY_ON_ADVISED  4'h5

// time-out counter geometry
`define WDR_CNT_W           15
`define WDR_SEL_BASE        8

// reset delay: time in ms, clock in kHz
`define WDR_RSTD_MS         50
`define WDR_CLK_KHZ         125000
`define WDR_RSTD_CYCLES     (`WDR_RSTD_MS * `WDR_CLK_KHZ)

// system clock divider ratio for the derived watchdog source
`define WDR_SYS_DIV         4
`define WDR_DIV_W           2

`endif

// [include/wdr_pkg.sv]
// types shared by the watchdog and reset control block
package wdr_pkg;

	// watchdog clock source options
	typedef enum logic [1:0] {
		WDR_SRC_CRYSTAL,
		WDR_SRC_SYS_DIV4,
		WDR_SRC_SLOW_RC
	} wdr_src_t;

	// fixed configuration options
	typedef struct packed {
		logic     wdt_en;
		wdr_src_t clk_src;
		logic     pair_mode;
	} wdr_cfg_t;

	// instruction strobes from the core, one-cycle pulses
	typedef struct packed {
		logic clr_single;
		logic clr_first;
		logic clr_second;
		logic halt;
	} wdr_instr_t;

	// data memory access for the block's registers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wdr_mem_t;

	// reset and run states
	typedef enum logic [1:0] {
		WDR_ST_HOLD,
		WDR_ST_DELAY,
		WDR_ST_RUN,
		WDR_ST_HALT
	} wdr_state_t;

endpackage

// [core/wdr_tick.sv]
// watchdog clock source selection and tick generation
`timescale 1ns/10ps
`include "wdr_map.svh"

module wdr_tick (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire wdr_pkg::wdr_src_t src,
	input  wire logic              halted,
	input  wire logic              crystal_clk,
	input  wire logic              slow_rc_clk,
	output logic                   tick
);

	logic [2:0]            xtal_q;
	logic [2:0]            rc_q;
	logic [`WDR_DIV_W-1:0] div_q;
	logic                  xtal_rise;
	logic                  rc_rise;
	logic                  div_wrap;
	logic                  tick_d;

	// two-stage synchronisers, third stage only for edge detection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			xtal_q <= 3'h0;
			rc_q   <= 3'h0;
		end else begin
			xtal_q <= {xtal_q[1:0], crystal_clk};
			rc_q   <= {rc_q[1:0], slow_rc_clk};
		end
	end

	// system clock divider, frozen while the core is halted
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			div_q <= '0;
		else if (!halted)
			div_q <= div_q + `WDR_DIV_W'(1);
	end

	// rising edges of the selected source
	assign xtal_rise = xtal_q[1] & ~xtal_q[2];
	assign rc_rise   = rc_q[1] & ~rc_q[2];
	assign div_wrap  = !halted && (div_q == `WDR_DIV_W'(`WDR_SYS_DIV - 1));
	assign tick_d    = (src == wdr_pkg::WDR_SRC_CRYSTAL)  ? xtal_rise :
	                   (src == wdr_pkg::WDR_SRC_SYS_DIV4) ? div_wrap  :
	                   (src == wdr_pkg::WDR_SRC_SLOW_RC)  ? rc_rise   :
	                   1'b0;

	// registered tick pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			tick <= 1'b0;
		else
			tick <= tick_d;
	end

endmodule

// [verif/watchdog_and_reset_control_tb_top.sv]
// self-checking testbench of the watchdog and reset control block
`timescale 1ns/10ps
`include "wdr_map.svh"

module watchdog_and_reset_control_tb_top;
	localparam int         RSTD  = 20;
	localparam logic [7:0] A_SEL = `WDR_ADDR_PERIOD_SEL;
	localparam logic [7:0] A_KEY = `WDR_ADDR_CTRL_ONE;
	localparam logic [7:0] A_STA = `WDR_ADDR_STATUS;
	logic                CLK = 1'b0;
	logic                NRST;
	logic                SLOW = 1'b0;
	wdr_pkg::wdr_cfg_t   CFG;
	wdr_pkg::wdr_instr_t INSTR;
	wdr_pkg::wdr_mem_t   MEM;
	logic                EXT_RESET_N;
	logic                LOW_SUPPLY_RESET;
	logic                WAKE_REQ;
	logic [7:0]          MEM_RDATA;
	logic                CORE_RESET;
	logic                PC_CLEAR;
	logic                PC_STACK_CLEAR;
	logic                PORT_PRESET;
	logic                HALTED;
	logic                TIMEOUT_FLAG;
	logic                POWERDOWN_FLAG;
	logic [24:0]         rows [7];
	int                  miscompares = 0;
	int                  checks = 0;
	int                  cyc = 0;
	int                  n;

	wdr_top #(.RSTD_CYCLES(RSTD)) DUT (
		.CLK             (CLK),
		.NRST            (NRST),
		.CFG             (CFG),
		.INSTR           (INSTR),
		.MEM             (MEM),
		.EXT_RESET_N     (EXT_RESET_N),
		.LOW_SUPPLY_RESET(LOW_SUPPLY_RESET),
		.WAKE_REQ        (WAKE_REQ),
		.CRYSTAL_CLK     (SLOW),
		.SLOW_RC_CLK     (SLOW),
		.MEM_RDATA       (MEM_RDATA),
		.CORE_RESET      (CORE_RESET),
		.PC_CLEAR        (PC_CLEAR),
		.PC_STACK_CLEAR  (PC_STACK_CLEAR),
		.PORT_PRESET     (PORT_PRESET),
		.HALTED          (HALTED),
		.TIMEOUT_FLAG    (TIMEOUT_FLAG),
		.POWERDOWN_FLAG  (POWERDOWN_FLAG)
	);

	// system clock and a free slow clock toggled on falling edges
	always #4 CLK = ~CLK;
	always #32 SLOW = ~SLOW;

	// hang guard
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tick(int k);
		repeat (k) @(posedge CLK);
		#1;
	endtask

	task automatic wr(logic [7:0] a, logic [7:0] d);
		MEM = '{1'b1, 1'b0, a, d};
		tick(1);
		MEM = '0;
		tick(1);
	endtask

	task automatic rd(logic [7:0] a, logic [7:0] exp);
		MEM = '{1'b0, 1'b1, a, 8'h00};
		tick(1);
		MEM = '0;
		tick(1);
		check("read_data", MEM_RDATA, exp);
	endtask

	task automatic ins(logic [3:0] v);
		INSTR = v;
		tick(1);
		INSTR = '0;
		tick(1);
	endtask

	// waits for the end of the reset delay
	task automatic wait_run();
		int k;
		k = 0;
		while (CORE_RESET !== 1'b0 && k < 100) begin
			tick(1);
			k++;
		end
		check("delay_len", k >= RSTD, 1'b1);
		check("core_reset", CORE_RESET, 1'b0);
		check("pc_clear", PC_CLEAR, 1'b0);
	endtask

	task automatic wait_rst(output int k);
		k = 0;
		while (CORE_RESET !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
	endtask

	task automatic por(wdr_pkg::wdr_cfg_t c);
		NRST = 1'b0;
		CFG = c;
		tick(8);
		check("por_reset", CORE_RESET, 1'b1);
		check("por_preset", PORT_PRESET, 1'b1);
		check("por_tmo", TIMEOUT_FLAG, 1'b0);
		check("por_pwrdn", POWERDOWN_FLAG, 1'b0);
		NRST = 1'b1;
		wait_run();
	endtask

	// main sequence
	initial begin
		NRST = 1'b0;
		CFG = '0;
		INSTR = '0;
		MEM = '0;
		EXT_RESET_N = 1'b1;
		LOW_SUPPLY_RESET = 1'b0;
		WAKE_REQ = 1'b0;
		// rows: write flag, address, write data, expected read
		rows = '{{1'b0, A_SEL, 8'h00, 8'h07}, {1'b0, A_KEY, 8'h00, 8'h0A},
			{1'b0, A_STA, 8'h00, 8'h00}, {1'b1, A_SEL, 8'hFF, 8'h07},
			{1'b1, A_SEL, 8'h02, 8'h02}, {1'b0, 8'h30, 8'h00, 8'h00},
			{1'b1, A_SEL, 8'h00, 8'h00}};
		por('{1'b0, wdr_pkg::WDR_SRC_SYS_DIV4, 1'b0});
		foreach (rows[i]) begin
			if (rows[i][24])
				wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
		end
		$display("test registers finished");
		// key off: no time-out and clears are no-ops
		ins(4'h8);
		tick(1200);
		check("off_reset", CORE_RESET, 1'b0);
		wr(A_KEY, 8'h05);
		wait_rst(n);
		check("tmo_time", n >= 1005 && n <= 1045, 1'b1);
		check("tmo_flag", TIMEOUT_FLAG, 1'b1);
		check("tmo_pc", PC_CLEAR, 1'b1);
		wait_run();
		rd(A_SEL, 8'h07);
		rd(A_STA, 8'h20);
		$display("test running time-out finished");
		// paired clearing keeps the device alive
		por('{1'b1, wdr_pkg::WDR_SRC_SYS_DIV4, 1'b1});
		wr(A_SEL, 8'h00);
		repeat (5) begin
			tick(600);
			ins(4'h4);
			ins(4'h2);
		end
		check("pair_alive", CORE_RESET, 1'b0);
		tick(500);
		ins(4'h4);
		ins(4'h8);
		wait_rst(n);
		check("pair_half", n + 505 >= 1005 && n + 505 <= 1045, 1'b1);
		wait_run();
		$display("test paired clear finished");
		// halt with divided system clock stops the count
		por('{1'b1, wdr_pkg::WDR_SRC_SYS_DIV4, 1'b0});
		wr(A_SEL, 8'h00);
		ins(4'h1);
		check("halted", HALTED, 1'b1);
		check("halt_pwrdn", POWERDOWN_FLAG, 1'b1);
		check("halt_tmo", TIMEOUT_FLAG, 1'b0);
		tick(2000);
		check("no_wake", HALTED, 1'b1);
		WAKE_REQ = 1'b1;
		tick(1);
		WAKE_REQ = 1'b0;
		tick(1);
		check("woken", HALTED, 1'b0);
		ins(4'h8);
		check("clr_pwrdn", POWERDOWN_FLAG, 1'b0);
		$display("test halt finished");
		// halted time-out on the slow clock wakes the core
		por('{1'b1, wdr_pkg::WDR_SRC_SLOW_RC, 1'b0});
		wr(A_SEL, 8'h00);
		ins(4'h1);
		n = 0;
		while (PC_STACK_CLEAR !== 1'b1 && n < 2700) begin
			tick(1);
			n++;
		end
		check("wake_time", n >= 1900 && n < 2700, 1'b1);
		tick(1);
		check("wake_run", HALTED, 1'b0);
		check("wake_rst", CORE_RESET, 1'b0);
		check("wake_tmo", TIMEOUT_FLAG, 1'b1);
		check("wake_pwrdn", POWERDOWN_FLAG, 1'b1);
		rd(A_SEL, 8'h00);
		$display("test halted time-out finished");
		// pin reset then low supply reset keep the flags
		EXT_RESET_N = 1'b0;
		tick(4);
		check("pin_rst", CORE_RESET, 1'b1);
		check("pin_pc", PC_CLEAR, 1'b1);
		EXT_RESET_N = 1'b1;
		wait_run();
		rd(A_STA, 8'h30);
		rd(A_SEL, 8'h07);
		LOW_SUPPLY_RESET = 1'b1;
		tick(4);
		check("low_rst", CORE_RESET, 1'b1);
		LOW_SUPPLY_RESET = 1'b0;
		wait_run();
		rd(A_STA, 8'h30);
		$display("test pin and low supply reset finished");
		// running time-out counted on the crystal source
		por('{1'b1, wdr_pkg::WDR_SRC_CRYSTAL, 1'b0});
		wr(A_SEL, 8'h00);
		wait_rst(n);
		check("xtal_time", n >= 1900 && n < 2700, 1'b1);
		check("xtal_tmo", TIMEOUT_FLAG, 1'b1);
		$display("test crystal source finished");
		finish_test();
	end
endmodule
